// file: common/zm_defs.vh
`ifndef ZM_DEFS_VH
`define ZM_DEFS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define ZM_OFS_CTRL        8'h00
`define ZM_OFS_ACTIVE      8'h04
`define ZM_OFS_MODE        8'h08
`define ZM_OFS_LEARN       8'h0c
`define ZM_OFS_POINT_THR   8'h10
`define ZM_OFS_WIDTH_THR   8'h14
`define ZM_OFS_CONTOUR_THR 8'h18
`define ZM_OFS_FORCE_MASK  8'h1c
`define ZM_OFS_STATUS      8'h20
`define ZM_OFS_QUERY       8'h24

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ZM_CTRL_TOOL_SEL   0
`define ZM_CTRL_EXCL_EN    1
`define ZM_FMASK_FORCE_LSB 4
`define ZM_ZONE_ALARM      0
`define ZM_ZONE_PREWARN    1
`define ZM_ZONE_ATTENTION  2

// ----------------------------------------
// Monitoring modes
// ----------------------------------------
`define ZM_MODE_POINT      2'h0
`define ZM_MODE_WIDTH      2'h1
`define ZM_MODE_CONTOUR    2'h2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ZM_RST_CTRL        32'h0000_0000
`define ZM_RST_ACTIVE      32'h0000_0001
`define ZM_RST_MODE        32'h5555_5555
`define ZM_RST_POINT_THR   32'h0000_0006
`define ZM_RST_WIDTH_THR   32'h0000_0006
`define ZM_RST_CONTOUR_THR 32'h0000_1814
`define ZM_RST_FORCE_MASK  32'h0000_0077

// ----------------------------------------
// Timing
// ----------------------------------------
`define ZM_CLK_KHZ         100000
`define ZM_SELECT_MS       1000
`define ZM_HOLD_MS         2000

`endif

// file: design/zm_signal_logic.v
// Behaviour
// - Point mode: zone fires when point count exceeds threshold past response cycles
// - Width mode: zone fires when target wider than threshold persists past existence cycles
// - Point and width modes give alarm, pre-warning and attention per group
// - Contour mode gives alarm only, on distance, length and time thresholds
// - After reset every group monitors in object-width mode
// - Normal-target learning only allowed on groups in width mode
// - With exclusion on, targets classed normal raise no signal in width-mode groups with learning set
// - Forced control only acts under tool group selection
// - Cancel input high suppresses the chosen signals until it drops
// - Force input high holds the chosen signals valid until it drops
// - Force beats cancel on the same signal
// - Per-signal masks choose forced signals, all selected after reset
// - Alarm, pre-warning, attention drive outputs two, three and four
// - Report status low six bits: alarm 0-1, pre-warning 2-3, attention 4-5
// - Odd report bit is the OR across all active groups
// - Status bit reads 1 when valid, 0 when invalid
// - Report group byte holds the group number from zero
// - Any signal change sends an unsolicited report
// - Changes from forced control also send a report
// - Pin selection: 4-bit group number held one second activates that group
// - A status query is answered with the same report format
// - An output once active stays active at least its minimum time
`timescale 1ns/100ps
`default_nettype none
`include "zm_defs.vh"

module zm_signal_logic #(
  parameter integer CNT_W         = 8,
  parameter integer SELECT_CYCLES = `ZM_SELECT_MS * `ZM_CLK_KHZ,
  parameter integer HOLD_CYCLES   = `ZM_HOLD_MS * `ZM_CLK_KHZ
) (
  // Clock and reset
  input  wire        clock,
  input  wire        reset_n,
  input  wire        clock_en,
  // AXI4-Lite slave
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Per-group scan results
  input  wire        meas_valid,
  input  wire [3:0]  meas_group,
  input  wire [23:0] meas_points,
  input  wire [29:0] meas_width,
  input  wire [2:0]  meas_normal,
  input  wire [9:0]  meas_contour_dist,
  input  wire [9:0]  meas_contour_len,
  // Discrete inputs
  input  wire        cancel_input,
  input  wire        force_input,
  input  wire        select_input_bit2,
  input  wire        select_input_bit3,
  // Discrete outputs
  output reg         alarm_output,
  output reg         prewarn_output,
  output reg         attention_output,
  // Status report
  output reg         report_valid,
  input  wire        report_ready,
  output reg  [7:0]  report_group,
  output reg  [7:0]  report_status
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function [31:0] zm_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  strb;
    integer b;
    begin
      zm_merge = old_v;
      for (b = 0; b < 4; b = b + 1)
        if (strb[b])
          zm_merge[b*8 +: 8] = new_v[b*8 +: 8];
    end
  endfunction

  function [31:0] zm_width_mask;
    input [31:0] mode_v;
    integer g;
    begin
      zm_width_mask = 32'h0000_0000;
      for (g = 0; g < 16; g = g + 1)
        zm_width_mask[g] = (mode_v[g*2 +: 2] == `ZM_MODE_WIDTH);
    end
  endfunction

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg  [31:0]      ctrl_reg;
  reg  [31:0]      active_reg;
  reg  [31:0]      mode_reg;
  reg  [31:0]      learn_reg;
  reg  [31:0]      point_thr_reg;
  reg  [31:0]      width_thr_reg;
  reg  [31:0]      contour_thr_reg;
  reg  [31:0]      fmask_reg;
  reg  [7:0]       awaddr_reg;
  reg  [31:0]      wdata_reg;
  reg  [3:0]       wstrb_reg;
  reg              aw_full_reg;
  reg              w_full_reg;
  reg  [47:0]      raw_reg;
  reg  [47:0]      final_reg;
  reg  [CNT_W-1:0] cnt_reg [0:47];
  reg  [15:0]      pend_reg;
  reg  [3:0]       sel_last_reg;
  reg  [31:0]      sel_cnt_reg;
  reg  [3:0]       sel_group_reg;
  reg  [31:0]      hold_reg [0:2];

  wire        tool_sel = ctrl_reg[`ZM_CTRL_TOOL_SEL];
  wire        excl_en  = ctrl_reg[`ZM_CTRL_EXCL_EN];
  wire [3:0]  sel_in   = {select_input_bit3, select_input_bit2, force_input, cancel_input};
  wire [15:0] active   = tool_sel ? active_reg[15:0] : (16'h0001 << sel_group_reg);
  wire        do_write = aw_full_reg && w_full_reg && !s_axi_bvalid;
  wire        query_wr = do_write && (awaddr_reg == `ZM_OFS_QUERY);

  assign s_axi_awready = !aw_full_reg;
  assign s_axi_wready  = !w_full_reg;
  assign s_axi_arready = !s_axi_rvalid;

  // ----------------------------------------
  // Forcing, OR and change detection
  // ----------------------------------------
  reg  [47:0] final_next;
  reg  [2:0]  or_sig;
  reg  [15:0] changed;
  reg  [2:0]  cmask;
  reg  [2:0]  fmask;
  integer     gi;

  always @*
  begin
    final_next = 48'h0;
    or_sig     = 3'h0;
    changed    = 16'h0;
    cmask      = (tool_sel && cancel_input) ? fmask_reg[2:0] : 3'h0;
    fmask      = (tool_sel && force_input) ? fmask_reg[`ZM_FMASK_FORCE_LSB +: 3] : 3'h0;
    for (gi = 0; gi < 16; gi = gi + 1)
    begin
      if (active[gi])
        final_next[gi*3 +: 3] = (raw_reg[gi*3 +: 3] & ~cmask) | fmask;
      or_sig      = or_sig | final_next[gi*3 +: 3];
      changed[gi] = (final_next[gi*3 +: 3] != final_reg[gi*3 +: 3]);
    end
  end

  // Lowest pending group goes first; higher groups wait their turn
  reg  [3:0] pick;
  integer    pi;

  always @*
  begin
    pick = 4'h0;
    for (pi = 15; pi >= 0; pi = pi - 1)
      if (pend_reg[pi])
        pick = pi[3:0];
  end

  wire        send = (|pend_reg) && (!report_valid || report_ready);
  wire [2:0]  pick_sig = final_reg[pick*3 +: 3];
  wire [15:0] query_set = query_wr ? (16'h0001 << wdata_reg[3:0]) : 16'h0000;

  // ----------------------------------------
  // Scan evaluation
  // ----------------------------------------
  reg  [2:0]       cond;
  reg  [CNT_W-1:0] resp;
  integer          z;

  always @*
  begin
    cond = 3'h0;
    resp = point_thr_reg[8 +: CNT_W];
    case (mode_reg[meas_group*2 +: 2])
      `ZM_MODE_POINT:
      begin
        for (z = 0; z < 3; z = z + 1)
          cond[z] = meas_points[z*8 +: 8] > point_thr_reg[7:0];
      end
      `ZM_MODE_WIDTH:
      begin
        resp = width_thr_reg[16 +: CNT_W];
        for (z = 0; z < 3; z = z + 1)
          cond[z] = (meas_width[z*10 +: 10] > width_thr_reg[9:0])
                    && !(excl_en && learn_reg[meas_group] && meas_normal[z]);
      end
      `ZM_MODE_CONTOUR:
      begin
        resp = contour_thr_reg[20 +: CNT_W];
        cond[`ZM_ZONE_ALARM] = (meas_contour_dist > contour_thr_reg[9:0])
                               && (meas_contour_len > contour_thr_reg[19:10]);
      end
      default:
        cond = 3'h0;
    endcase
  end

  // ----------------------------------------
  // Sequential logic
  // ----------------------------------------
  integer k;

  always @(posedge clock)
  begin
    if (!reset_n)
    begin
      ctrl_reg        <= `ZM_RST_CTRL;
      active_reg      <= `ZM_RST_ACTIVE;
      mode_reg        <= `ZM_RST_MODE;
      learn_reg       <= 32'h0000_0000;
      point_thr_reg   <= `ZM_RST_POINT_THR;
      width_thr_reg   <= `ZM_RST_WIDTH_THR;
      contour_thr_reg <= `ZM_RST_CONTOUR_THR;
      fmask_reg       <= `ZM_RST_FORCE_MASK;
      awaddr_reg      <= 8'h00;
      wdata_reg       <= 32'h0000_0000;
      wstrb_reg       <= 4'h0;
      aw_full_reg     <= 1'b0;
      w_full_reg      <= 1'b0;
      s_axi_bvalid    <= 1'b0;
      s_axi_bresp     <= 2'h0;
      s_axi_rvalid    <= 1'b0;
      s_axi_rresp     <= 2'h0;
      s_axi_rdata     <= 32'h0000_0000;
      raw_reg         <= 48'h0;
      final_reg       <= 48'h0;
      pend_reg        <= 16'h0;
      sel_last_reg    <= 4'h0;
      sel_cnt_reg     <= 32'h0000_0000;
      sel_group_reg   <= 4'h0;
      report_valid    <= 1'b0;
      report_group    <= 8'h00;
      report_status   <= 8'h00;
      alarm_output    <= 1'b0;
      prewarn_output  <= 1'b0;
      attention_output <= 1'b0;
      for (k = 0; k < 48; k = k + 1)
        cnt_reg[k] <= {CNT_W{1'b0}};
      for (k = 0; k < 3; k = k + 1)
        hold_reg[k] <= 32'h0000_0000;
    end
    else if (clock_en)
    begin
      // Bus write side: address and data caught in either order
      if (s_axi_awvalid && !aw_full_reg)
      begin
        awaddr_reg  <= s_axi_awaddr;
        aw_full_reg <= 1'b1;
      end
      if (s_axi_wvalid && !w_full_reg)
      begin
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
        w_full_reg <= 1'b1;
      end
      if (do_write)
      begin
        aw_full_reg  <= 1'b0;
        w_full_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= 2'h0;
        case (awaddr_reg)
          `ZM_OFS_CTRL:        ctrl_reg        <= zm_merge(ctrl_reg, wdata_reg, wstrb_reg) & 32'h0000_0003;
          `ZM_OFS_ACTIVE:      active_reg      <= zm_merge(active_reg, wdata_reg, wstrb_reg) & 32'h0000_ffff;
          `ZM_OFS_MODE:        mode_reg        <= zm_merge(mode_reg, wdata_reg, wstrb_reg);
          `ZM_OFS_LEARN:       learn_reg       <= zm_merge(learn_reg, wdata_reg, wstrb_reg)
                                                  & zm_width_mask(mode_reg);
          `ZM_OFS_POINT_THR:   point_thr_reg   <= zm_merge(point_thr_reg, wdata_reg, wstrb_reg);
          `ZM_OFS_WIDTH_THR:   width_thr_reg   <= zm_merge(width_thr_reg, wdata_reg, wstrb_reg);
          `ZM_OFS_CONTOUR_THR: contour_thr_reg <= zm_merge(contour_thr_reg, wdata_reg, wstrb_reg);
          `ZM_OFS_FORCE_MASK:  fmask_reg       <= zm_merge(fmask_reg, wdata_reg, wstrb_reg) & 32'h0000_0077;
          `ZM_OFS_STATUS,
          `ZM_OFS_QUERY:       s_axi_bresp     <= 2'h0;
          default:             s_axi_bresp     <= 2'h3;
        endcase
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      // Changing a group's mode drops learning it may no longer hold
      if (!do_write)
        learn_reg <= learn_reg & zm_width_mask(mode_reg);

      // Bus read side
      if (s_axi_arvalid && !s_axi_rvalid)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'h0;
        case (s_axi_araddr)
          `ZM_OFS_CTRL:        s_axi_rdata <= ctrl_reg;
          `ZM_OFS_ACTIVE:      s_axi_rdata <= active_reg;
          `ZM_OFS_MODE:        s_axi_rdata <= mode_reg;
          `ZM_OFS_LEARN:       s_axi_rdata <= learn_reg;
          `ZM_OFS_POINT_THR:   s_axi_rdata <= point_thr_reg;
          `ZM_OFS_WIDTH_THR:   s_axi_rdata <= width_thr_reg;
          `ZM_OFS_CONTOUR_THR: s_axi_rdata <= contour_thr_reg;
          `ZM_OFS_FORCE_MASK:  s_axi_rdata <= fmask_reg;
          `ZM_OFS_STATUS:      s_axi_rdata <= {2'h0, force_input, cancel_input, active,
                                               sel_group_reg, 5'h00, or_sig};
          `ZM_OFS_QUERY:       s_axi_rdata <= 32'h0000_0000;
          default:
          begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h3;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;

      // Pin group selection needs the pattern stable for the full window
      if (sel_in != sel_last_reg)
      begin
        sel_last_reg <= sel_in;
        sel_cnt_reg  <= 32'h0000_0000;
      end
      else if (sel_cnt_reg < SELECT_CYCLES - 1)
        sel_cnt_reg <= sel_cnt_reg + 32'h0000_0001;
      else
        sel_group_reg <= sel_last_reg;

      // One result per group per scan; counts saturate instead of wrapping
      if (meas_valid)
      begin
        for (k = 0; k < 3; k = k + 1)
        begin
          if (!cond[k] || !active[meas_group])
            cnt_reg[meas_group*3+k] <= {CNT_W{1'b0}};
          else if (cnt_reg[meas_group*3+k] != {CNT_W{1'b1}})
            cnt_reg[meas_group*3+k] <= cnt_reg[meas_group*3+k] + 1'b1;
          raw_reg[meas_group*3+k] <= cond[k] && active[meas_group]
                                     && (cnt_reg[meas_group*3+k] >= resp);
        end
      end

      final_reg <= final_next;
      pend_reg  <= (pend_reg & ~(send ? (16'h0001 << pick) : 16'h0000))
                   | changed | query_set;

      if (send)
      begin
        report_valid  <= 1'b1;
        report_group  <= {4'h0, pick};
        report_status <= {2'b00, or_sig[2], pick_sig[2], or_sig[1], pick_sig[1],
                          or_sig[0], pick_sig[0]};
      end
      else if (report_ready)
        report_valid <= 1'b0;

      // Minimum on-time counted from the rising edge of each output
      for (k = 0; k < 3; k = k + 1)
      begin
        if (or_sig[k] && hold_reg[k] == 32'h0000_0000 && !(k == 0 ? alarm_output :
            k == 1 ? prewarn_output : attention_output))
          hold_reg[k] <= HOLD_CYCLES - 1;
        else if (hold_reg[k] != 32'h0000_0000)
          hold_reg[k] <= hold_reg[k] - 32'h0000_0001;
      end
      // Rising edge plus HOLD_CYCLES-1 counted cycles gives the full minimum on-time
      alarm_output     <= or_sig[0] || (hold_reg[0] != 32'h0000_0000);
      prewarn_output   <= or_sig[1] || (hold_reg[1] != 32'h0000_0000);
      attention_output <= or_sig[2] || (hold_reg[2] != 32'h0000_0000);
    end
  end

endmodule

`default_nettype wire

// file: verification/zm_signal_logic_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module zm_signal_logic_assertions #(
  parameter integer HOLD_CYCLES = 8
) (
  // Clock and reset
  input wire logic        clock,
  input wire logic        reset_n,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  // Outputs and report
  input wire logic        alarm_output,
  input wire logic        report_valid,
  input wire logic        report_ready,
  input wire logic [7:0]  report_group,
  input wire logic [7:0]  report_status
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  // Cycles since the alarm output rose; a counter because the hold is a parameter
  logic [31:0] hold_reg;
  always @(posedge clock)
    if (!reset_n)
      hold_reg <= 32'h0;
    else if ($rose(alarm_output))
      hold_reg <= 32'h1;
    else if (hold_reg != 32'h0 && hold_reg < HOLD_CYCLES)
      hold_reg <= hold_reg + 32'h1;
    else
      hold_reg <= 32'h0;
  a_report_stands: assert property (report_valid && !report_ready
    |=> report_valid && $stable(report_status) && $stable(report_group)) else $error("Report changed early");
  a_status_top_zero: assert property (report_valid |-> report_status[7:6] == 2'h0)
    else $error("Report status top bits set");
  a_or_covers_own: assert property (report_valid
    |-> (report_status[5:0] & 6'h15 & ~(report_status[5:0] >> 1)) == 6'h0) else $error("OR bit missing");
  a_group_range: assert property (report_valid |-> report_group < 8'h10)
    else $error("Report group out of range");
  a_alarm_hold: assert property (hold_reg != 32'h0 && hold_reg < HOLD_CYCLES |-> alarm_output)
    else $error("Alarm output dropped early");
  a_alarm_report: assert property ($rose(alarm_output) |-> ##[0:40] (report_valid && report_status[1]))
    else $error("No report for alarm");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:3] s_axi_bvalid) else $error("Write not answered");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:3] s_axi_rvalid)
    else $error("Read not answered");
  a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr >= 8'h28
    |=> s_axi_rvalid && s_axi_rresp == 2'h3 && s_axi_rdata == 32'h0) else $error("Unmapped read not refused");
  c_report: cover property (report_valid && report_ready);
  c_alarm: cover property ($rose(alarm_output));
  c_all_set: cover property (report_valid && report_status[5:0] == 6'h3f);
endmodule
bind zm_signal_logic zm_signal_logic_assertions #(.HOLD_CYCLES(HOLD_CYCLES)) u_check (.*);
`default_nettype wire

// file: verification/zm_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module zm_host_model (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       reset_n,
  // Pacing
  input  wire logic       slow,
  // Report channel
  input  wire logic       report_valid,
  output logic            report_ready,
  input  wire logic [7:0] report_group,
  input  wire logic [7:0] report_status,
  // Last report taken
  output logic [7:0]      last_group,
  output logic [7:0]      last_status,
  output logic [15:0]     n_reports
);
  logic tick_reg;
  // A slow host takes only every other cycle, so reports must stand
  assign report_ready = !slow || tick_reg;
  always @(posedge clock)
    if (!reset_n)
    begin
      tick_reg <= 1'h0;
      last_group <= 8'h0;
      last_status <= 8'h0;
      n_reports <= 16'h0;
    end
    else
    begin
      tick_reg <= ~tick_reg;
      if (report_valid && report_ready)
      begin
        last_group <= report_group;
        last_status <= report_status;
        n_reports <= n_reports + 16'h1;
      end
    end
endmodule
`default_nettype wire

// file: verification/test_zm_signal_logic.sv
`timescale 1ns/100ps
`default_nettype none
`include "zm_defs.vh"
module test_zm_signal_logic;
  logic        clock, reset_n, clock_en, slow, meas_valid, cancel_input, force_input;
  logic        select_input_bit2, select_input_bit3, alarm_output, prewarn_output, attention_output;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, report_valid, report_ready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, report_group, report_status, last_group, last_status;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0]  s_axi_wstrb, meas_group;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [23:0] meas_points;
  logic [29:0] meas_width;
  logic [2:0]  meas_normal;
  logic [9:0]  meas_contour_dist, meas_contour_len;
  logic [15:0] n_reports, base;
  integer      mismatches, n_checks;
  zm_signal_logic #(.SELECT_CYCLES(8), .HOLD_CYCLES(8)) dut (.*);
  zm_host_model host (.*);
  initial
  begin
    clock = 1'h0;
    forever #5 clock = ~clock;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks = n_checks + 1;
    if (got !== exp)
    begin
      mismatches = mismatches + 1;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic settle;
    repeat (24) @(posedge clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
    begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do
    begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    rdat = s_axi_rresp == 2'h3 ? {16'hdec0, s_axi_rdata[15:0]} : s_axi_rdata;
    s_axi_rready <= 1'h0;
  endtask
  task automatic scan(input logic [3:0] g, input logic [23:0] p, input logic [29:0] w,
                      input logic [19:0] c, input logic [2:0] n);
    @(posedge clock);
    meas_group <= g;
    meas_points <= p;
    meas_width <= w;
    {meas_contour_len, meas_contour_dist} <= c;
    meas_normal <= n;
    meas_valid <= 1'h1;
    @(posedge clock);
    meas_valid <= 1'h0;
    settle;
  endtask
  task automatic sc(input logic [23:0] p, input logic [29:0] w, input logic [19:0] c,
                    input logic [2:0] n, input logic [7:0] e);
    scan(4'h0, p, w, c, n);
    chk(last_status, e);
  endtask
  task automatic pins(input logic c, input logic f);
    @(posedge clock);
    cancel_input <= c;
    force_input <= f;
    settle;
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    rd(`ZM_OFS_MODE);
    chk(rdat, 32'h5555_5555);
    rd(`ZM_OFS_FORCE_MASK);
    chk(rdat, 32'h77);
    rd(`ZM_OFS_POINT_THR);
    chk(rdat, 32'h6);
    rd(`ZM_OFS_WIDTH_THR);
    chk(rdat, 32'h6);
    rd(`ZM_OFS_CONTOUR_THR);
    chk(rdat, 32'h1814);
    rd(8'h40);
    chk(rdat, 32'hdec0_0000);
    $display("regs done");
  endtask
  task automatic t_pin;
    sc(24'h0, 30'h7, 20'h0, 3'h0, 8'h03);
    pins(1'h1, 1'h0);
    pins(1'h0, 1'h0);
    chk(last_status, 8'h03);
    chk(alarm_output, 1'h1);
    $display("pin mode done");
  endtask
  task automatic t_force;
    wr(`ZM_OFS_CTRL, 32'h1);
    sc(24'h0, {10'h7, 10'h7, 10'h6}, 20'h0, 3'h0, 8'h3c);
    chk({alarm_output, prewarn_output, attention_output}, 3'h3);
    slow = 1'h1;
    base = n_reports;
    pins(1'h1, 1'h0);
    chk({last_status, attention_output}, 9'h0);
    pins(1'h1, 1'h1);
    chk({last_status, alarm_output}, 9'h7f);
    pins(1'h0, 1'h1);
    chk(last_status, 8'h3f);
    pins(1'h0, 1'h0);
    chk(last_status, 8'h3c);
    chk(n_reports - base, 32'h3);
    wr(`ZM_OFS_FORCE_MASK, 32'h74);
    pins(1'h1, 1'h0);
    chk(last_status, 8'h0c);
    pins(1'h0, 1'h0);
    slow = 1'h0;
    $display("force done");
  endtask
  task automatic t_modes;
    wr(`ZM_OFS_MODE, 32'h0);
    wr(`ZM_OFS_POINT_THR, 32'h0206);
    sc(24'h7, 30'h0, 20'h0, 3'h0, 8'h00);
    sc(24'h7, 30'h0, 20'h0, 3'h0, 8'h00);
    sc(24'h7, 30'h0, 20'h0, 3'h0, 8'h03);
    sc(24'h6, 30'h0, 20'h0, 3'h0, 8'h00);
    sc(24'h7, 30'h0, 20'h0, 3'h0, 8'h00);
    wr(`ZM_OFS_POINT_THR, 32'h6);
    sc(24'h07_0700, 30'h0, 20'h0, 3'h0, 8'h3c);
    wr(`ZM_OFS_MODE, 32'h2);
    sc(24'h09_0909, 30'h9, {10'h7, 10'h15}, 3'h0, 8'h03);
    sc(24'h09_0909, 30'h9, {10'h7, 10'h14}, 3'h0, 8'h00);
    wr(`ZM_OFS_MODE, 32'h0);
    wr(`ZM_OFS_LEARN, 32'h1);
    rd(`ZM_OFS_LEARN);
    chk(rdat, 32'h0);
    wr(`ZM_OFS_MODE, 32'h5555_5555);
    wr(`ZM_OFS_CTRL, 32'h3);
    wr(`ZM_OFS_LEARN, 32'h1);
    rd(`ZM_OFS_LEARN);
    chk(rdat, 32'h1);
    sc(24'h0, {10'h7, 20'h0}, 20'h0, 3'h0, 8'h30);
    sc(24'h0, {10'h7, 20'h0}, 20'h0, 3'h4, 8'h00);
    $display("modes done");
  endtask
  task automatic t_query;
    sc(24'h0, 30'h0, 20'h0, 3'h0, 8'h00);
    wr(`ZM_OFS_ACTIVE, 32'h3);
    scan(4'h1, 24'h0, 30'h7, 20'h0, 3'h0);
    base = n_reports;
    wr(`ZM_OFS_QUERY, 32'h0);
    settle;
    chk(n_reports - base, 32'h1);
    chk({last_group, last_status}, 16'h0002);
    rd(`ZM_OFS_STATUS);
    chk(rdat, 32'h0000_3001);
    wr(`ZM_OFS_QUERY, 32'h1);
    settle;
    chk({last_group, last_status}, 16'h0103);
    $display("query done");
  endtask
  initial
  begin
    mismatches = 0;
    n_checks = 0;
    {reset_n, slow, meas_valid, cancel_input, force_input} = 5'h0;
    {select_input_bit2, select_input_bit3} = 2'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {meas_group, meas_points, meas_width, meas_normal} = 61'h0;
    {meas_contour_dist, meas_contour_len} = 20'h0;
    s_axi_wstrb = 4'hf;
    clock_en = 1'h1;
    repeat (12) @(posedge clock);
    reset_n <= 1'h1;
    settle;
    t_regs;
    t_pin;
    t_force;
    t_modes;
    t_query;
    finish_test;
  end
  initial
  begin
    repeat (20000) @(posedge clock);
    mismatches = mismatches + 1;
    finish_test;
  end
endmodule
`default_nettype wire
